// File: rtl/lt_pkg.sv
// constants, register map and types of the stairway light timer
// Function
// - stairway mode: rising trigger edge switches the light on
// - stairway mode: falling trigger edge starts the elapsed count, light stays on
// - stairway mode: light goes off when elapsed count reaches off-delay
// - stairway mode: prewarning drops light for its length, offset before off-delay end
// - stairway mode: optional retrigger restarts the running elapsed count
// - prewarning offset and length follow time base: 750/50 ms, 15/1 s, 15/1 min
// - default prewarning uses fixed 15 s offset (1 min in hour base), ignoring set offset and length
// - retentive option keeps timer state and light across power loss
// - each timing parameter may come from another block's actual value
// - multi-function mode: rising trigger edge switches the light on
// - multi-function mode: trigger held for hold time latches permanent light
// - multi-function mode: trigger falling before hold time starts off-delay
// - multi-function mode: light goes off when elapsed count equals off-delay
// - multi-function mode: optional prewarning drops light before off-delay end
// - multi-function mode: further trigger while active clears count and light
// - multi-function mode: reset input clears elapsed count and light
// - reduced variant: only hold time and off-delay, no prewarning, no reset
package lt_pkg;
  // ----------------------------------------
  // clock and time base
  // ----------------------------------------
  localparam int CLK_HZ = 200_000_000;
  localparam int UNIT_MS = 10;
  localparam int UNIT_CYC = CLK_HZ / 1000 * UNIT_MS;
  localparam int UNITS_PER_S = 100;
  localparam int S_PER_MIN = 60;
  localparam int W = 16;
  localparam int SEL_W = 4;
  localparam logic [W-1:0] PW_OFS_SEC = 16'(750 / UNIT_MS);
  localparam logic [W-1:0] PW_LEN_SEC = 16'(50 / UNIT_MS);
  localparam logic [W-1:0] PW_OFS_MIN = 16'h000F;
  localparam logic [W-1:0] PW_LEN_MIN = 16'h0001;
  localparam logic [W-1:0] PW_OFS_HR = 16'h000F;
  localparam logic [W-1:0] PW_LEN_HR = 16'h0001;
  localparam int DEF_PW_S = 15;
  localparam logic [W-1:0] DEF_OFS_SEC = 16'(DEF_PW_S * UNITS_PER_S);
  localparam logic [W-1:0] DEF_OFS_MIN = 16'(DEF_PW_S);
  localparam logic [W-1:0] DEF_OFS_HR = 16'h0001;
  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_OFFDLY = 5'h04;
  localparam logic [4:0] ADDR_PWOFS = 5'h08;
  localparam logic [4:0] ADDR_PWLEN = 5'h0C;
  localparam logic [4:0] ADDR_HOLD = 5'h10;
  localparam logic [4:0] ADDR_SRCSEL = 5'h14;
  localparam logic [4:0] ADDR_STATUS = 5'h18;
  localparam logic [4:0] ADDR_ELAPSED = 5'h1C;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam int CTRL_RETRIG = 6;
  localparam int CTRL_RETAIN = 7;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    LT_STAIR = 2'b00,
    LT_MULTI = 2'b01,
    LT_REDUCED = 2'b10,
    LT_MODE_RSV = 2'b11
  } lt_mode_type;
  typedef enum logic [1:0] {
    LT_BASE_SEC = 2'b00,
    LT_BASE_MIN = 2'b01,
    LT_BASE_HR = 2'b10,
    LT_BASE_RSV = 2'b11
  } lt_base_type;
  typedef enum logic [1:0] {
    LT_PW_OFF = 2'b00,
    LT_PW_TABLE = 2'b01,
    LT_PW_EXPL = 2'b10,
    LT_PW_DEF = 2'b11
  } lt_pw_type;
  typedef enum logic [1:0] {
    LT_IDLE = 2'b00,
    LT_HELD = 2'b01,
    LT_RUN = 2'b10,
    LT_PERM = 2'b11
  } lt_fsm_type;
endpackage

// File: rtl/lt_tick_div.sv
// tick divider: one pulse every DIV enabled cycles
`timescale 1ns/1ps
`default_nettype none
module lt_tick_div #(
  parameter int DIV = 100
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // tick chain
  input wire logic en_i,
  output logic tick_o
);
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } lt_div_type;
  lt_div_type div_r;
  lt_div_type div_nxt;
  always_comb begin
    div_nxt = div_r;
    div_nxt.tick = 1'b0;
    if (en_i) begin
      if (div_r.cnt == 32'(DIV - 1)) begin
        div_nxt.cnt = 32'h00000000;
        div_nxt.tick = 1'b1;
      end else begin
        div_nxt.cnt = div_r.cnt + 32'h00000001;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_r <= '0;
    end else begin
      div_r <= div_nxt;
    end
  end
  assign tick_o = div_r.tick;
endmodule // lt_tick_div
`default_nettype wire

// File: rtl/lt_light_timer.sv
// stairway / multi-function light timer with avalon-mm register slave
//
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module lt_light_timer import lt_pkg::*; #(
  parameter int NSRC = 4,
  parameter int UNIT_CYCLES = UNIT_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // avalon-mm slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // timer inputs
  input wire logic scan_i,
  input wire logic trg_i,
  input wire logic reset_in_i,
  input wire logic power_restore_i,
  input wire logic [NSRC*W-1:0] ext_actual_i,
  // lamp
  output logic light_o
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic wait_n;
    logic [31:0] rdata;
    logic [7:0] ctrl;
    logic [W-1:0] offdly;
    logic [W-1:0] pwofs;
    logic [W-1:0] pwlen;
    logic [W-1:0] hold;
    logic [4*SEL_W-1:0] srcsel;
    lt_fsm_type st;
    logic [W-1:0] elapsed_count;
    logic trg_prev;
    logic pend;
    logic light;
  } lt_state_type;
  lt_state_type state_r;
  lt_state_type state_nxt;

  // ----------------------------------------
  // time base ticks
  // ----------------------------------------
  logic tick_unit;
  logic tick_sec;
  logic tick_min;
  logic tick_sel;
  lt_tick_div #(.DIV(UNIT_CYCLES)) u_div_unit (
    .clk_i(clk_i), .rst_i(rst_i), .en_i(1'b1), .tick_o(tick_unit));
  lt_tick_div #(.DIV(UNITS_PER_S)) u_div_sec (
    .clk_i(clk_i), .rst_i(rst_i), .en_i(tick_unit), .tick_o(tick_sec));
  lt_tick_div #(.DIV(S_PER_MIN)) u_div_min (
    .clk_i(clk_i), .rst_i(rst_i), .en_i(tick_sec), .tick_o(tick_min));

  // ----------------------------------------
  // parameter selection
  // ----------------------------------------
  lt_mode_type mode;
  lt_base_type tbase;
  lt_pw_type pwsel;
  logic [W-1:0] t_off;
  logic [W-1:0] t_hold;
  logic [W-1:0] t_ofs;
  logic [W-1:0] t_len;
  logic pw_en;
  logic pw_win;

  function automatic logic [W-1:0] pick(input logic [W-1:0] cval, input logic [SEL_W-1:0] sel,
                                        input logic [NSRC*W-1:0] ext);
    logic [W-1:0] v;
    v = cval;
    for (int i = 0; i < NSRC; i++) begin
      if (sel == SEL_W'(i + 1)) begin
        v = ext[i*W +: W];
      end
    end
    return v;
  endfunction

  function automatic logic pw_hit(input logic [W-1:0] c, input logic [W-1:0] t,
                                  input logic [W-1:0] o, input logic [W-1:0] l, input logic en);
    logic [W:0] pos;
    pos = {1'b0, c} + {1'b0, o};
    return en && (pos >= {1'b0, t}) && (pos < ({1'b0, t} + {1'b0, l}));
  endfunction

  always_comb begin
    mode = lt_mode_type'(state_r.ctrl[1:0]);
    tbase = lt_base_type'(state_r.ctrl[3:2]);
    pwsel = lt_pw_type'(state_r.ctrl[5:4]);
    t_off = pick(state_r.offdly, state_r.srcsel[0 +: SEL_W], ext_actual_i);
    t_hold = pick(state_r.hold, state_r.srcsel[3*SEL_W +: SEL_W], ext_actual_i);
    case (tbase)
      LT_BASE_MIN: begin
        t_ofs = PW_OFS_MIN;
        t_len = PW_LEN_MIN;
        tick_sel = tick_sec;
      end
      LT_BASE_HR: begin
        t_ofs = PW_OFS_HR;
        t_len = PW_LEN_HR;
        tick_sel = tick_min;
      end
      default: begin
        t_ofs = PW_OFS_SEC;
        t_len = PW_LEN_SEC;
        tick_sel = tick_unit;
      end
    endcase
    case (pwsel)
      LT_PW_EXPL: begin
        t_ofs = pick(state_r.pwofs, state_r.srcsel[SEL_W +: SEL_W], ext_actual_i);
        t_len = pick(state_r.pwlen, state_r.srcsel[2*SEL_W +: SEL_W], ext_actual_i);
      end
      LT_PW_DEF: begin
        case (tbase)
          LT_BASE_MIN: t_ofs = DEF_OFS_MIN;
          LT_BASE_HR: t_ofs = DEF_OFS_HR;
          default: t_ofs = DEF_OFS_SEC;
        endcase
      end
      default: begin
      end
    endcase
    pw_en = (pwsel != LT_PW_OFF) && (mode != LT_REDUCED);
    pw_win = pw_hit(state_r.elapsed_count, t_off, t_ofs, t_len, pw_en);
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic rise;
  logic fall;
  logic adv;
  logic rst_act;
  logic multi;
  always_comb begin
    state_nxt = state_r;
    multi = (mode == LT_MULTI) || (mode == LT_REDUCED);
    rise = scan_i && trg_i && !state_r.trg_prev;
    fall = scan_i && !trg_i && state_r.trg_prev;
    adv = scan_i && state_r.pend;
    rst_act = scan_i && reset_in_i && (mode == LT_MULTI);
    // bus slave
    state_nxt.wait_n = 1'b1;
    if ((avs_read_i || avs_write_i) && state_r.wait_n) begin
      state_nxt.wait_n = 1'b0;
      case (avs_address_i & 5'h1C)
        ADDR_CTRL: state_nxt.rdata = {24'h000000, state_r.ctrl};
        ADDR_OFFDLY: state_nxt.rdata = {16'h0000, state_r.offdly};
        ADDR_PWOFS: state_nxt.rdata = {16'h0000, state_r.pwofs};
        ADDR_PWLEN: state_nxt.rdata = {16'h0000, state_r.pwlen};
        ADDR_HOLD: state_nxt.rdata = {16'h0000, state_r.hold};
        ADDR_SRCSEL: state_nxt.rdata = {16'h0000, state_r.srcsel};
        ADDR_STATUS: state_nxt.rdata = {28'h0000000, state_r.st, state_r.trg_prev, state_r.light};
        ADDR_ELAPSED: state_nxt.rdata = {16'h0000, state_r.elapsed_count};
        default: state_nxt.rdata = 32'h00000000;
      endcase
    end
    if (avs_write_i && !state_r.wait_n) begin
      case (avs_address_i & 5'h1C)
        ADDR_CTRL: if (avs_byteenable_i[0]) state_nxt.ctrl = avs_writedata_i[7:0];
        ADDR_OFFDLY: state_nxt.offdly = be16(state_r.offdly);
        ADDR_PWOFS: state_nxt.pwofs = be16(state_r.pwofs);
        ADDR_PWLEN: state_nxt.pwlen = be16(state_r.pwlen);
        ADDR_HOLD: state_nxt.hold = be16(state_r.hold);
        ADDR_SRCSEL: state_nxt.srcsel = be16(state_r.srcsel);
        default: begin
        end
      endcase
    end
    // tick pending until the next scan; a new tick wins over the consume
    if (scan_i) begin
      state_nxt.pend = 1'b0;
    end
    if (tick_sel) begin
      state_nxt.pend = 1'b1;
    end
    // timer, evaluated once per scan
    if (power_restore_i) begin
      if (!state_r.ctrl[CTRL_RETAIN]) begin
        state_nxt.st = LT_IDLE;
        state_nxt.elapsed_count = '0;
      end
    end else if (scan_i) begin
      state_nxt.trg_prev = trg_i;
      if (rst_act) begin
        state_nxt.st = LT_IDLE;
        state_nxt.elapsed_count = '0;
      end else begin
        case (state_r.st)
          LT_IDLE: begin
            if (rise) begin
              state_nxt.st = LT_HELD;
              state_nxt.elapsed_count = '0;
            end
          end
          LT_HELD: begin
            if (fall) begin
              state_nxt.st = LT_RUN;
              state_nxt.elapsed_count = '0;
            end else if (multi) begin
              if (state_r.elapsed_count >= t_hold) begin
                state_nxt.st = LT_PERM;
              end else if (adv) begin
                state_nxt.elapsed_count = state_r.elapsed_count + 16'h0001;
              end
            end
          end
          LT_RUN: begin
            if (multi && rise) begin
              state_nxt.st = LT_IDLE;
              state_nxt.elapsed_count = '0;
            end else if (!multi && rise && state_r.ctrl[CTRL_RETRIG]) begin
              state_nxt.st = LT_HELD;
            end else if (state_r.elapsed_count >= t_off) begin
              state_nxt.st = LT_IDLE;
            end else if (adv) begin
              state_nxt.elapsed_count = state_r.elapsed_count + 16'h0001;
            end
          end
          LT_PERM: begin
            if (rise) begin
              state_nxt.st = LT_IDLE;
              state_nxt.elapsed_count = '0;
            end
          end
          default: state_nxt.st = LT_IDLE;
        endcase
      end
    end
    // light follows state; prewarning gap inside the off-delay
    case (state_nxt.st)
      LT_IDLE: state_nxt.light = 1'b0;
      LT_RUN: state_nxt.light = !pw_hit(state_nxt.elapsed_count, t_off, t_ofs, t_len, pw_en);
      default: state_nxt.light = 1'b1;
    endcase
  end

  function automatic logic [W-1:0] be16(input logic [W-1:0] old);
    logic [W-1:0] v;
    v = old;
    if (avs_byteenable_i[0]) v[7:0] = avs_writedata_i[7:0];
    if (avs_byteenable_i[1]) v[15:8] = avs_writedata_i[15:8];
    return v;
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= '0;
      state_r.wait_n <= 1'b1;
      state_r.ctrl <= CTRL_RST;
    end else begin
      state_r <= state_nxt;
    end
  end
  assign avs_readdata_o = state_r.rdata;
  assign avs_waitrequest_o = state_r.wait_n;
  assign light_o = state_r.light;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic quiet;
  assign quiet = !power_restore_i && !rst_act;

  trigger_on_a: assert property (
    state_r.st == LT_IDLE && rise && quiet
    |=> light_o && state_r.st == LT_HELD) else $error("light not on after trigger edge");
  fall_start_a: assert property (
    state_r.st == LT_HELD && fall && quiet
    |=> state_r.st == LT_RUN && state_r.elapsed_count == 16'h0000) else $error("count not started");
  stair_lit_a: assert property (
    mode == LT_STAIR && state_r.st == LT_RUN && !pw_en
    |-> light_o) else $error("light dropped while counting");
  delay_end_a: assert property (
    state_r.st == LT_RUN && scan_i && !rise && quiet && state_r.elapsed_count >= t_off
    |=> !light_o && state_r.st == LT_IDLE) else $error("light not off at off-delay");
  count_bound_a: assert property (
    state_r.st == LT_RUN
    |-> state_r.elapsed_count <= t_off) else $error("count ran past off-delay");
  prewarn_gap_a: assert property (
    state_r.st == LT_RUN && pw_win
    |-> !light_o) else $error("prewarning gap missing");
  retrig_a: assert property (
    mode == LT_STAIR && state_r.ctrl[CTRL_RETRIG] && state_r.st == LT_RUN && rise && quiet
    |=> state_r.st == LT_HELD ##1 state_r.light) else $error("retrigger failed");
  table_ofs_a: assert property (
    state_r.st == LT_RUN && pwsel == LT_PW_TABLE && tbase == LT_BASE_SEC && pw_en
    && state_r.elapsed_count + PW_OFS_SEC == t_off |-> !light_o) else $error("table prewarning not applied");
  default_ofs_a: assert property (
    state_r.st == LT_RUN && pwsel == LT_PW_DEF && tbase == LT_BASE_SEC && pw_en
    && state_r.elapsed_count + DEF_OFS_SEC == t_off |-> !light_o) else $error("default prewarning not applied");
  multi_on_a: assert property (
    multi && state_r.st == LT_IDLE && rise && quiet
    |=> light_o && state_r.st == LT_HELD) else $error("multi light not on after trigger edge");
  perm_latch_a: assert property (
    multi && state_r.st == LT_HELD && scan_i && trg_i && quiet && state_r.elapsed_count >= t_hold
    |=> state_r.st == LT_PERM && light_o) else $error("no latch");
  hold_bound_a: assert property (
    multi && state_r.st == LT_HELD
    |-> state_r.elapsed_count <= t_hold) else $error("hold count ran past hold time");
  early_fall_a: assert property (
    multi && state_r.st == LT_HELD && fall && quiet && state_r.elapsed_count < t_hold
    |=> state_r.st == LT_RUN && state_r.elapsed_count == 16'h0000) else $error("off-delay not started");
  multi_end_a: assert property (
    multi && state_r.st == LT_RUN && scan_i && !rise && quiet && state_r.elapsed_count == t_off
    |=> !light_o) else $error("multi light not off at off-delay");
  multi_warn_a: assert property (
    mode == LT_MULTI && state_r.st == LT_RUN && pw_win
    |-> !light_o) else $error("multi prewarning gap missing");
  toggle_off_a: assert property (
    multi && (state_r.st == LT_RUN || state_r.st == LT_PERM) && rise && quiet
    |=> !light_o && state_r.elapsed_count == 16'h0000) else $error("toggle off failed");
  reset_in_a: assert property (
    scan_i && reset_in_i && mode == LT_MULTI && !power_restore_i
    |=> !light_o && state_r.elapsed_count == 16'h0000) else $error("reset input ignored");
  reduced_a: assert property (
    mode == LT_REDUCED && state_r.st == LT_RUN && scan_i && reset_in_i && !rise && !power_restore_i
    && state_r.elapsed_count < t_off |=> state_r.st == LT_RUN) else $error("reduced variant reset");
  reduced_warn_a: assert property (
    mode == LT_REDUCED && state_r.st == LT_RUN
    |-> light_o) else $error("reduced variant prewarned");
  retain_a: assert property (
    power_restore_i && state_r.ctrl[CTRL_RETAIN]
    |=> state_r.st == $past(state_r.st)) else $error("retained state lost");
  loss_clear_a: assert property (
    power_restore_i && !state_r.ctrl[CTRL_RETAIN]
    |=> state_r.st == LT_IDLE && !light_o && state_r.elapsed_count == 16'h0000) else $error("state kept at restart");
  advance_a: assert property (
    state_r.st == LT_RUN && adv && !rise && quiet && state_r.elapsed_count < t_off
    |=> state_r.elapsed_count == $past(state_r.elapsed_count) + 16'h0001) else $error("no advance");
  count_hold_a: assert property (
    state_r.st == LT_RUN && !scan_i && !power_restore_i
    |=> $stable(state_r.elapsed_count)) else $error("count moved between scans");
  ack_once_a: assert property (
    !avs_waitrequest_o
    |=> avs_waitrequest_o) else $error("waitrequest low too long");
  idle_wait_a: assert property (
    avs_waitrequest_o && !avs_read_i && !avs_write_i
    |=> avs_waitrequest_o) else $error("acknowledge without request");

  // ----------------------------------------
  // cover points
  // ----------------------------------------
  cover_stair_c: cover property (mode == LT_STAIR && state_r.st == LT_RUN ##1 state_r.st == LT_IDLE);
  cover_perm_c: cover property (state_r.st == LT_PERM);
  cover_pw_c: cover property (state_r.st == LT_RUN && pw_win);
  cover_toggle_c: cover property (state_r.st == LT_PERM && rise ##1 state_r.st == LT_IDLE);
  cover_loss_c: cover property (power_restore_i && state_r.st == LT_PERM);
endmodule // lt_light_timer
`default_nettype wire

// File: bench/lt_lamp_model.sv
// push-button and lamp model at the far side of the light timer
`timescale 1ns/1ps
`default_nettype none
module lt_lamp_model #(
  parameter int GAP = 500
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // button and lamp
  input wire logic press_i,
  input wire logic light_i,
  output logic trg_o,
  // episode report
  output logic done_o,
  output logic [15:0] first_o,
  output logic [15:0] last_o,
  output logic [3:0] drops_o
);
  // ----------------------------------------
  // button contact and lamp episode tracking
  // ----------------------------------------
  logic act_r;
  logic lp_r;
  logic [15:0] cnt_r;
  logic [15:0] dark_r;
  always_ff @(posedge clk_i) begin
    trg_o <= press_i;
    lp_r <= light_i;
    done_o <= 1'b0;
    if (rst_i) begin
      act_r <= 1'b0;
      dark_r <= 16'h0000;
    end else begin
      if (act_r) cnt_r <= cnt_r + 16'h0001;
      if (light_i && !act_r) begin
        act_r <= 1'b1;
        cnt_r <= 16'h0001;
        drops_o <= 4'h0;
      end
      if (act_r && lp_r && !light_i) begin
        drops_o <= drops_o + 4'h1;
        last_o <= cnt_r;
        if (drops_o == 4'h0) first_o <= cnt_r;
      end
      dark_r <= (act_r && !light_i) ? dark_r + 16'h0001 : 16'h0000;
      if (act_r && dark_r == 16'(GAP)) begin
        act_r <= 1'b0;
        done_o <= 1'b1;
      end
    end
  end
endmodule // lt_lamp_model
`default_nettype wire

// File: bench/tb_top.sv
// self-checking testbench of the light timer
`timescale 1ns/1ps
`default_nettype none
module tb_top import lt_pkg::*; ;
  typedef struct {logic [7:0] ctrl; int t, src, p, act, gap, first, last, tol, drops;} lt_case_type;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic scan_r = 1'b0;
  logic press_r = 1'b0;
  logic reset_in = 1'b0;
  logic power_restore = 1'b0;
  logic [63:0] ext_actual = 64'h0;
  logic trg, light, done;
  logic [15:0] first, last, lf;
  logic [3:0] drops;
  logic [31:0] q;
  int error_cnt = 0;
  int total_checks = 0;
  lt_case_type expq[$];
  lt_case_type mc;
  lt_case_type cases[16] = '{
    '{8'h00, 10, 0, 8, 0, 0, 48, 48, 8, 1}, '{8'h20, 20, 0, 8, 0, 0, 76, 88, 8, 2},
    '{8'h10, 100, 0, 8, 0, 0, 108, 408, 8, 2}, '{8'h30, 1600, 0, 8, 0, 0, 408, 6408, 8, 2},
    '{8'h14, 20, 0, 8, 0, 0, 2008, 8008, 400, 2}, '{8'h40, 10, 0, 8, 1, 20, 76, 76, 8, 1},
    '{8'h00, 10, 0, 8, 1, 20, 48, 48, 8, 1}, '{8'h01, 10, 0, 8, 0, 0, 48, 48, 8, 1},
    '{8'h21, 20, 0, 8, 0, 0, 76, 88, 8, 2}, '{8'h01, 50, 0, 80, 1, 40, 120, 120, 8, 1},
    '{8'h01, 50, 0, 8, 1, 20, 28, 28, 8, 1}, '{8'h01, 50, 0, 8, 2, 20, 28, 28, 8, 1},
    '{8'h22, 20, 0, 8, 2, 20, 88, 88, 8, 1}, '{8'h81, 50, 0, 80, 3, 40, 140, 140, 8, 1},
    '{8'h00, 99, 1, 8, 0, 0, 48, 48, 8, 1}, '{8'h01, 50, 0, 80, 3, 40, 120, 350, 8, 2}};
  // ----------------------------------------
  // design, far side and clock
  // ----------------------------------------
  lt_light_timer #(.UNIT_CYCLES(4)) u_lt_light_timer (
    .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address), .avs_read_i(avs_read),
    .avs_write_i(avs_write), .avs_writedata_i(avs_writedata), .avs_byteenable_i(4'hF),
    .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest), .scan_i(scan_r),
    .trg_i(trg), .reset_in_i(reset_in), .power_restore_i(power_restore),
    .ext_actual_i(ext_actual), .light_o(light));
  lt_lamp_model u_lt_lamp_model (
    .clk_i(clk_i), .rst_i(rst_i), .press_i(press_r), .light_i(light), .trg_o(trg),
    .done_o(done), .first_o(first), .last_o(last), .drops_o(drops));
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) scan_r <= ~scan_r;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic chk_ep(input lt_case_type c, input logic [15:0] f, input logic [15:0] l, input logic [3:0] d);
    logic ok;
    ok = d == 4'(c.drops) && f >= 16'(c.first - c.tol) && f <= 16'(c.first + 16);
    ok = ok && l >= 16'(c.last - c.tol) && l <= 16'(c.last + 16);
    total_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] episode expected %0d/%0d/%0d seen %0d/%0d/%0d", c.first, c.last, c.drops, f, l, d);
    end
  endtask
  task automatic bus(input logic [4:0] a, input logic wr, input logic [31:0] d);
    int n;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 50) begin
      error_cnt++;
      conclude();
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd_chk(input string nm, input logic [4:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0000_0000);
    chk(nm, e, q);
  endtask
  task automatic press(input int p);
    press_r <= 1'b1;
    repeat (p) @(posedge clk_i);
    press_r <= 1'b0;
  endtask
  // ----------------------------------------
  // lamp episode monitor
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (done === 1'b1) begin
      if (expq.size() == 0) chk("unexpected episode", 32'h0, 32'h1);
      else begin
        mc = expq.pop_front();
        chk_ep(mc, first, last, drops);
      end
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int i, n;
    lf = 16'h0030;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd_chk("ctrl", ADDR_CTRL, 32'h0000_0000);
    rd_chk("elapsed", ADDR_ELAPSED, 32'h0000_0000);
    lf = lfsr(lf);
    bus(ADDR_OFFDLY, 1'b1, {16'hFFFF, lf});
    rd_chk("offdly", ADDR_OFFDLY, {16'h0000, lf});
    bus(ADDR_STATUS, 1'b1, 32'hFFFF_FFFF);
    rd_chk("status", ADDR_STATUS, 32'h0000_0000);
    bus(ADDR_PWOFS, 1'b1, 32'h0000_0003);
    bus(ADDR_PWLEN, 1'b1, 32'h0000_0002);
    bus(ADDR_HOLD, 1'b1, 32'h0000_000A);
    rd_chk("hold", ADDR_HOLD, 32'h0000_000A);
    $display("test registers done");
    lf = lfsr(lf);
    ext_actual <= {lf, ~lf, lf ^ 16'h5A5A, 16'h000A};
    for (i = 0; i < 16; i++) begin
      bus(ADDR_CTRL, 1'b1, {24'h0, cases[i].ctrl});
      bus(ADDR_OFFDLY, 1'b1, cases[i].t);
      bus(ADDR_SRCSEL, 1'b1, cases[i].src);
      expq.push_back(cases[i]);
      press(cases[i].p);
      repeat (cases[i].gap) @(posedge clk_i);
      case (cases[i].act)
        1: press(8);
        2: begin
          reset_in <= 1'b1;
          repeat (4) @(posedge clk_i);
          reset_in <= 1'b0;
        end
        3: begin
          power_restore <= 1'b1;
          @(posedge clk_i);
          power_restore <= 1'b0;
          repeat (19) @(posedge clk_i);
          press(8);
        end
        default: ;
      endcase
      for (n = 0; n < 20000 && expq.size() != 0; n++) @(posedge clk_i);
      if (expq.size() != 0) begin
        error_cnt++;
        conclude();
      end
      $display("test %0d done", i);
    end
    conclude();
  end
endmodule // tb_top
`default_nettype wire
